/* File: rrmc_pkg.sv */
// constants and types of the radio reset and mode control block
// What this block does
// - while reset is active, ignore every command on the serial interface
// - after any reset the block runs in sensitive mode
// - normal mode disables the supply glitch detector
// - writing one to bit 0 of buffer-and-reset-mode command selects normal mode
// - command code FE00h triggers a software reset
// - software reset acts only in sensitive mode
// - software reset equals power-on reset but lasts about 0.25 ms
// - every reset returns configuration registers to their defaults
// - in sensitive mode a fast rising supply glitch enters reset
// - falling supply resets at 250 mV normal, 1.6 V sensitive
// - supply below about 1.6 V holds reset in sensitive mode
package rrmc_pkg;
  localparam int        CLK_MHZ          = 100;
  localparam int        POR_TIME_US      = 100_000;
  localparam int        SWR_TIME_US      = 250;
  localparam int        POR_CYCLES       = POR_TIME_US * CLK_MHZ;
  localparam int        SWR_CYCLES       = SWR_TIME_US * CLK_MHZ;
  localparam int        CNT_W            = 24;
  localparam logic [15:0] SOFT_RESTART_OPCODE = 16'hFE00;
  localparam logic [7:0]  CFG_CMD_HI       = 8'hCA;
  localparam int        MODE_BIT         = 0;
  localparam logic [7:0]  CFG_RESET_VAL    = 8'h00;

  typedef enum logic [1:0]
  {
    RRMC_RUN   = 2'b00,
    RRMC_HOLD  = 2'b01,
    RRMC_COUNT = 2'b10
  } rrmc_state_t;
endpackage

/* File: rrmc_timer.sv */
// down counter timing the length of a reset event
`timescale 1ns/10ps
module rrmc_timer
  import rrmc_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (load)
      nxt_cnt = load_val;
    else if (cnt_ff != '0)
      nxt_cnt = cnt_ff - CNT_W'(1);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign done = (cnt_ff == '0) && !load;
endmodule

/* File: rrmc_core.sv */
// reset sequencing, mode selection and command gating
`timescale 1ns/10ps
module rrmc_core
  import rrmc_pkg::*;
#(
  parameter int POR_LEN = POR_CYCLES,
  parameter int SWR_LEN = SWR_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        below_1v6,
  input  wire logic        below_250mv,
  input  wire logic        ramp_over_thr,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  output logic             chip_reset,
  output logic             cmd_accept,
  output logic             sensitive_mode,
  output logic             glitch_det_en,
  output logic [7:0]       cfg_low,
  output logic             cfg_write
);
  ////////////////////////////////////////////////////////////////////////
  rrmc_state_t      state_ff;
  rrmc_state_t      nxt_state;
  logic             normal_ff;
  logic             nxt_normal;
  logic [7:0]       cfg_ff;
  logic [7:0]       nxt_cfg;
  logic             cfgw_ff;
  logic             nxt_cfgw;
  logic             load;
  logic [CNT_W-1:0] load_val;
  logic             done;
  logic             por_cond;
  logic             glitch;
  logic             swr_cmd;
  logic             cfg_cmd;
  logic [CNT_W-1:0] rst_run_ff;
  logic [CNT_W-1:0] nxt_rst_run;
  logic             soft_ff;
  logic             nxt_soft;

  rrmc_timer u_timer
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (load_val),
    .done     (done)
  );

  ////////////////////////////////////////////////////////////////////////
  // falling threshold depends on mode
  // low supply always holds reset in sensitive mode
  assign por_cond = normal_ff ? below_250mv : below_1v6;
  // glitch detector off in normal mode
  assign glitch_det_en = !normal_ff;
  // fast rise glitch only when sensitive
  assign glitch = glitch_det_en && ramp_over_thr;
  assign cmd_accept = (state_ff == RRMC_RUN);
  assign swr_cmd = cmd_valid && cmd_accept && (cmd_word == SOFT_RESTART_OPCODE) && !normal_ff;
  assign cfg_cmd = cmd_valid && cmd_accept && (cmd_word[15:8] == CFG_CMD_HI);

  always_comb
  begin
    nxt_state = state_ff;
    load      = 1'b0;
    load_val  = CNT_W'(POR_LEN);
    unique case (state_ff)
      RRMC_RUN:
      begin
        if (por_cond || glitch)
          nxt_state = RRMC_HOLD;
        else if (swr_cmd)
        begin
          load      = 1'b1;
          load_val  = CNT_W'(SWR_LEN);
          nxt_state = RRMC_COUNT;
        end
      end
      RRMC_HOLD:
      begin
        // held while supply low; timer restarts once it recovers
        load = 1'b1;
        if (!por_cond && !glitch)
          nxt_state = RRMC_COUNT;
      end
      RRMC_COUNT:
      begin
        if (por_cond || glitch)
          nxt_state = RRMC_HOLD;
        else if (done)
          nxt_state = RRMC_RUN;
      end
      default:
        nxt_state = RRMC_HOLD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_normal = normal_ff;
    nxt_cfg    = cfg_ff;
    nxt_cfgw   = 1'b0;
    // defaults restored whenever reset is active
    if (state_ff != RRMC_RUN)
    begin
      nxt_normal = 1'b0;
      nxt_cfg    = CFG_RESET_VAL;
    end
    // bit 0 of config selects normal mode
    // gated by cmd_accept, nothing latched in reset
    else if (cfg_cmd)
    begin
      nxt_cfg    = cmd_word[7:0];
      nxt_normal = cmd_word[MODE_BIT];
      nxt_cfgw   = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff  <= RRMC_HOLD;
      normal_ff <= 1'b0;
      cfg_ff    <= CFG_RESET_VAL;
      cfgw_ff   <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      normal_ff <= nxt_normal;
      cfg_ff    <= nxt_cfg;
      cfgw_ff   <= nxt_cfgw;
    end
  end

  assign chip_reset     = (state_ff != RRMC_RUN);
  assign sensitive_mode = !normal_ff;
  assign cfg_low        = cfg_ff;
  assign cfg_write      = cfgw_ff;

  ////////////////////////////////////////////////////////////////////////
  // length of the running reset, helper for the checks below
  always_comb
  begin
    nxt_rst_run = '0;
    nxt_soft    = soft_ff;
    if (chip_reset && (rst_run_ff != '1))
      nxt_rst_run = rst_run_ff + CNT_W'(1);
    else if (chip_reset)
      nxt_rst_run = rst_run_ff;
    // a supply event during a soft restart turns it into a full one
    if (swr_cmd)
      nxt_soft = 1'b1;
    else if (!chip_reset || (state_ff == RRMC_HOLD))
      nxt_soft = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_run_ff <= '0;
      soft_ff    <= 1'b0;
    end
    else
    begin
      rst_run_ff <= nxt_rst_run;
      soft_ff    <= nxt_soft;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // no command taken in reset
  no_cmd_rst_a: assert property (@(posedge clock) disable iff (!rst_n)
    chip_reset |-> !cmd_accept && !swr_cmd && !cfg_cmd)
    else $error("command accepted in reset");
  // no config write follows a reset-time command
  no_cfg_rst_a: assert property (@(posedge clock) disable iff (!rst_n)
    chip_reset |=> !cfg_write) else $error("config written during reset");
  sens_after_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(chip_reset) |-> sensitive_mode) else $error("not sensitive after reset");
  det_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !sensitive_mode |-> !glitch_det_en) else $error("glitch detector on in normal");
  mode_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_cmd && cmd_word[MODE_BIT] |=> !sensitive_mode) else $error("normal mode not set");
  // soft restart ignored in normal mode
  swr_norm_a: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_valid && cmd_accept && normal_ff && (cmd_word == SOFT_RESTART_OPCODE)
    && !por_cond |=> !chip_reset) else $error("soft restart in normal mode");
  swr_go_a: assert property (@(posedge clock) disable iff (!rst_n)
    swr_cmd |=> chip_reset) else $error("soft restart ignored");
  low_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    below_1v6 && sensitive_mode |=> chip_reset) else $error("reset released at low supply");
  glitch_rst_a: assert property (@(posedge clock) disable iff (!rst_n)
    ramp_over_thr && sensitive_mode |=> chip_reset) else $error("glitch missed");
  cfg_clr_a: assert property (@(posedge clock) disable iff (!rst_n)
    chip_reset |=> cfg_low == CFG_RESET_VAL) else $error("config not cleared");
  thr_norm_a: assert property (@(posedge clock) disable iff (!rst_n)
    below_250mv && !sensitive_mode |=> chip_reset) else $error("normal mode drop missed");
  norm_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    !chip_reset && !sensitive_mode && !below_250mv |=> !chip_reset)
    else $error("reset in normal mode without drop");
  soft_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(chip_reset) && soft_ff |-> rst_run_ff == CNT_W'(SWR_LEN + 1))
    else $error("soft restart length wrong");
  rst_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(chip_reset) |-> rst_run_ff > CNT_W'(SWR_LEN)) else $error("reset too short");

  swr_c:    cover property (@(posedge clock) disable iff (!rst_n) swr_cmd);
  normal_c: cover property (@(posedge clock) disable iff (!rst_n) $fell(sensitive_mode));
  glitch_c: cover property (@(posedge clock) disable iff (!rst_n) glitch && cmd_accept);
  soft_c:   cover property (@(posedge clock) disable iff (!rst_n)
    $fell(chip_reset) && soft_ff);
  drop_c:   cover property (@(posedge clock) disable iff (!rst_n)
    below_250mv && !sensitive_mode);
endmodule

/* File: rrmc_host_model.sv */
// behavioural host issuing commands on the serial control side
`timescale 1ns/10ps
module rrmc_host_model
(
  input  wire logic        clock,
  input  wire logic        send,
  input  wire logic [15:0] word,
  output logic             cmd_valid,
  output logic [15:0]      cmd_word
);
  // whole word per command
  // idle word shows the inverse so a stale command is never reused
  always @(posedge clock)
  begin
    cmd_valid <= send;
    cmd_word  <= send ? word : ~word;
  end
endmodule

/* File: tb_radio_reset_mode_control.sv */
// self-checking bench of the reset and mode control core
`timescale 1ns/10ps
module tb_radio_reset_mode_control;
  import rrmc_pkg::*;
  localparam int POR_T = 50;
  localparam int SWR_T = 20;
  logic        clock, rst_n, below_1v6, below_250mv, ramp_over_thr, send;
  logic        cmd_valid, chip_reset, cmd_accept, sensitive_mode, glitch_det_en;
  logic        cfg_write;
  logic [15:0] word, cmd_word;
  logic [7:0]  cfg_low;
  int          err_total, compares, cyc, n;
  rrmc_core #(.POR_LEN(POR_T), .SWR_LEN(SWR_T)) DUT (.clock(clock), .rst_n(rst_n),
    .below_1v6(below_1v6), .below_250mv(below_250mv), .ramp_over_thr(ramp_over_thr),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .chip_reset(chip_reset),
    .cmd_accept(cmd_accept), .sensitive_mode(sensitive_mode),
    .glitch_det_en(glitch_det_en), .cfg_low(cfg_low), .cfg_write(cfg_write));
  rrmc_host_model host (.clock(clock), .send(send), .word(word),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic cmd(input logic [15:0] w);
    @(posedge clock);
    send <= 1'b1;
    word <= w;
    @(posedge clock);
    send <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_free(input int lim);
    n = 0;
    while (chip_reset !== 1'b0 && n < lim)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic supply(input logic lo, input logic off, input logic ramp);
    @(posedge clock);
    below_1v6 <= lo;
    below_250mv <= off;
    ramp_over_thr <= ramp;
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    step(1);
    chk(8'(cmd_accept), 8'h00);
    chk(8'(sensitive_mode), 8'h01);
    chk(8'(glitch_det_en), 8'h01);
    cmd(16'hCA01);
    wait_free(POR_T + 10);
    chk(8'(n >= POR_T - 10 && n <= POR_T + 2), 8'h01);
    chk(cfg_low, 8'h00);
    chk(8'(sensitive_mode), 8'h01);
  endtask
  task automatic t_normal_mode;
    cmd(16'hCA01);
    // write pulse lasts one cycle, look just after the edge
    #1;
    chk({cfg_low[6:0], cfg_write}, 8'h03);
    chk(8'(glitch_det_en), 8'h00);
    supply(1'b1, 1'b0, 1'b1);
    supply(1'b0, 1'b0, 1'b0);
    step(1);
    chk(8'(chip_reset), 8'h00);
    cmd(SOFT_RESTART_OPCODE);
    step(2);
    chk(8'(chip_reset), 8'h00);
    supply(1'b1, 1'b1, 1'b0);
    step(2);
    chk(8'(chip_reset), 8'h01);
    chk(8'(sensitive_mode), 8'h01);
    supply(1'b0, 1'b0, 1'b0);
    wait_free(POR_T + 10);
    chk({cfg_low[6:0], sensitive_mode}, 8'h01);
  endtask
  task automatic t_soft_and_glitch;
    cmd(16'hCA02);
    cmd(SOFT_RESTART_OPCODE);
    // config clears one cycle into reset, look just after the edge
    #1;
    chk({cfg_low[6:0], chip_reset}, 8'h05);
    wait_free(SWR_T + 10);
    chk(8'(n >= SWR_T - 3 && n <= SWR_T + 3), 8'h01);
    chk(cfg_low, 8'h00);
    supply(1'b0, 1'b0, 1'b1);
    supply(1'b0, 1'b0, 1'b0);
    step(2);
    chk(8'(chip_reset), 8'h01);
    wait_free(POR_T + 10);
    supply(1'b1, 1'b0, 1'b0);
    step(POR_T + 20);
    chk(8'(chip_reset), 8'h01);
    supply(1'b0, 1'b0, 1'b0);
    wait_free(POR_T + 10);
    chk(8'(cmd_accept), 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // cycle ceiling well above the roughly 340 cycles of the run
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  initial
  begin
    {rst_n, below_1v6, below_250mv, ramp_over_thr, send} = 5'h00;
    word = 16'h0000;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_power_on();
    t_normal_mode();
    t_soft_and_glitch();
    tally_and_finish();
  end
endmodule
